// *** rtl/nvbac_top.sv ***
// Non-volatile data byte access controller: registers, read, guarded write
//
// What this block does
// - Setting fetch bit loads addressed byte into data register two cycles later.
// - Data register holds fetched byte until next read or software write.
// - Store starts only after 55h, AAh to unlock, then store go bit.
// - Store go bit cannot be set unless store permit bit is set.
// - Hardware never clears the store permit bit.
// - Clearing permit during a running store does not affect it.
// - On store completion, go bit clears and done flag sets.
// - Done flag stays set until software clears it.
// - Control register resets to zero except fault flag.
// - Location and data registers keep contents across non-power-on resets.
// - Done interrupt gated by its enable bit 6 and global enable.
// - Done flag sets regardless of either interrupt enable.
`timescale 1ns/1ps
module nvbac_top
    import nvbac_pkg::*;
(
    // Clock and resets
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_por,
    // Register port from the core
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    // Interrupt control register bits held by the core
    input  wire logic       i_global_irq_enable,
    input  wire logic       i_store_done_irq_enable,
    // Status
    output logic            o_store_busy,
    output logic            o_store_done_irq
);
`include "nvbac_defines.svh"
    localparam logic [15:0] STORE_CYC = 16'(`NVBAC_STORE_CYCLES);

    // Bus side and memory side
    nvbac_bus_req_t req;
    nvbac_mem_req_t mem_req;
    logic [7:0]     mem_rdata;
    logic           armed;

    // Register state
    logic [7:0]  loc_q, loc_d;
    logic [7:0]  byte_q, byte_d;
    logic        permit_q, permit_d;
    logic        store_q, store_d;
    logic        done_q, done_d;
    logic        fault_q, fault_d;
    logic        fetch_pend_q, fetch_pend_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        irq_q, irq_d;
    logic        store_seen_q;

    // Decode and sequencing strobes
    logic wr_ctrl, wr_data, wr_loc, go_req, start, finish;

    assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};

    // Register write decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_data = 1'b0;
        wr_loc  = 1'b0;
        if (!i_reg_wr) begin
            wr_ctrl = 1'b0;
        end else if (i_reg_addr == `NVBAC_OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (i_reg_addr == `NVBAC_OFS_DATA) begin
            wr_data = 1'b1;
        end else if (i_reg_addr == `NVBAC_OFS_LOC) begin
            wr_loc = 1'b1;
        end
    end

    // Go request needs permit already set, unlock armed, and no store running
    assign go_req = wr_ctrl && i_reg_wdata[`NVBAC_BIT_STORE] && !store_q;
    assign start  = go_req && permit_q && armed;
    assign finish = store_q && (cnt_q == 16'h0001);

    nvbac_unlock i_nvbac_unlock (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_req     (req),
        .i_consume (wr_ctrl && armed),
        .o_armed   (armed)
    );

    // Memory strobes: read on fetch, program one byte at the end of the cycle
    always_comb begin
        mem_req.rd    = wr_ctrl && i_reg_wdata[`NVBAC_BIT_FETCH] && !store_q && !start;
        mem_req.wr    = finish;
        mem_req.loc   = loc_q[5:0];
        mem_req.wdata = byte_q;
    end

    nvbac_mem i_nvbac_mem (
        .i_clock (i_clock),
        .i_req   (mem_req),
        .o_rdata (mem_rdata)
    );

    // Control and data next state
    always_comb begin
        loc_d        = loc_q;
        byte_d       = byte_q;
        permit_d     = permit_q;
        store_d      = store_q;
        done_d       = done_q;
        fault_d      = fault_q;
        fetch_pend_d = mem_req.rd;
        cnt_d        = cnt_q;
        if (wr_loc && !store_q) begin
            loc_d = i_reg_wdata; // Location frozen while a store runs
        end
        if (fetch_pend_q) begin
            byte_d = mem_rdata;
        end else if (wr_data && !store_q) begin
            byte_d = i_reg_wdata;
        end
        if (wr_ctrl) begin
            permit_d = i_reg_wdata[`NVBAC_BIT_PERMIT];
            fault_d  = fault_q & i_reg_wdata[`NVBAC_BIT_FAULT];
            done_d   = done_q & i_reg_wdata[`NVBAC_BIT_DONE];
        end
        if (start) begin
            store_d = 1'b1;
            cnt_d   = STORE_CYC;
        end else if (store_q) begin
            cnt_d = cnt_q - 16'h0001; // Permit is not looked at here
            if (finish) begin
                store_d = 1'b0;
            end
        end
        // Completion wins over a simultaneous software clear
        if (finish) begin
            done_d = 1'b1;
        end
    end

    // Read mux, registered
    always_comb begin
        rdata_d = rdata_q;
        if (!i_reg_rd) begin
            rdata_d = rdata_q;
        end else if (i_reg_addr == `NVBAC_OFS_DATA) begin
            rdata_d = byte_q;
        end else if (i_reg_addr == `NVBAC_OFS_LOC) begin
            rdata_d = loc_q;
        end else if (i_reg_addr == `NVBAC_OFS_CTRL) begin
            rdata_d = {3'b000, done_q, fault_q, permit_q, store_q, 1'b0};
        end else begin
            rdata_d = 8'h00; // Unlock register and unmapped read zero
        end
        irq_d = done_d && i_store_done_irq_enable && i_global_irq_enable;
    end

    // Control register: cleared by i_rst only (i_por alone leaves it), fault kept on warm reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            permit_q     <= 1'b0;
            store_q      <= 1'b0;
            done_q       <= 1'b0;
            fetch_pend_q <= 1'b0;
            cnt_q        <= 16'h0000;
            rdata_q      <= `NVBAC_CTRL_RESET;
            irq_q        <= 1'b0;
        end else begin
            permit_q     <= permit_d;
            store_q      <= store_d;
            done_q       <= done_d;
            fetch_pend_q <= fetch_pend_d;
            cnt_q        <= cnt_d;
            rdata_q      <= rdata_d;
            irq_q        <= irq_d;
        end
    end

    // Fault flag is condition dependent: only power-on or a software zero clears it. Reset kills the
    // go bit at once, so the running store is remembered one edge back.
    always_ff @(posedge i_clock or posedge i_por) begin
        if (i_por) begin
            fault_q      <= 1'b0;
            store_seen_q <= 1'b0;
        end else begin
            fault_q      <= (i_rst && store_seen_q) ? 1'b1 : fault_d;
            store_seen_q <= store_q && !finish;
        end
    end

    // Location and data survive warm resets; power-on gives a known zero, one
    // legal choice for unknown, so no unknown reaches the array strobes
    always_ff @(posedge i_clock or posedge i_por) begin
        if (i_por) begin
            loc_q  <= 8'h00;
            byte_q <= 8'h00;
        end else if (!i_rst) begin
            loc_q  <= loc_d;
            byte_q <= byte_d;
        end
    end

    assign o_reg_rdata      = rdata_q;
    assign o_store_busy     = store_q;
    assign o_store_done_irq = irq_q;

    // Checks kept beside the register logic; all run on the one clock
    // Fetched byte lands in the data register two edges after the strobe
    AST_FETCH_NEXT: assert property (@(posedge i_clock) disable iff (i_rst)
        mem_req.rd |-> ##2 (byte_q == $past(mem_rdata)))
        else $error("Fetched byte not loaded");

    // Data register only moves on a fetch or a software write
    AST_DATA_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
        (!fetch_pend_q && !wr_data) |=> $stable(byte_q))
        else $error("Data register changed without cause");

    // Location and data stay frozen while the array is being programmed
    AST_STORE_FREEZE: assert property (@(posedge i_clock) disable iff (i_rst)
        store_q |=> ($stable(loc_q) && $stable(byte_q)))
        else $error("Location or data moved during a store");

    // A go bit without the unlock sequence is ignored
    AST_GO_NEEDS_ARM: assert property (@(posedge i_clock) disable iff (i_rst)
        (go_req && !armed) |=> !store_q)
        else $error("Store began without unlock");

    // The unlock register is write only and reads as zero
    AST_UNLOCK_READS_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == `NVBAC_OFS_UNLOCK) |=> (o_reg_rdata == 8'h00))
        else $error("Unlock register read not zero");

    // Permit must already be set when the go bit is written
    AST_NO_PERMIT_NO_GO: assert property (@(posedge i_clock) disable iff (i_rst)
        (go_req && !permit_q) |=> !store_q)
        else $error("Store began without permit");

    // Hardware never touches the permit bit
    AST_PERMIT_SW_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
        !wr_ctrl |=> $stable(permit_q))
        else $error("Permit changed without write");

    // A started store keeps running for its first cycles
    AST_STORE_RUNS: assert property (@(posedge i_clock) disable iff (i_rst)
        start |=> store_q [*8])
        else $error("Store cycle aborted early");

    // The programming time is loaded whole at the start
    AST_STORE_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
        start |=> (cnt_q == STORE_CYC))
        else $error("Store counter not loaded");

    // Only the end of the count can stop a running store
    AST_STORE_TO_END: assert property (@(posedge i_clock) disable iff (i_rst)
        (store_q && !finish) |=> store_q)
        else $error("Store stopped before its end");

    // Completion clears go and raises done
    AST_DONE_ON_FINISH: assert property (@(posedge i_clock) disable iff (i_rst)
        finish |=> (done_q && !store_q))
        else $error("Completion not flagged");

    // Done stays set until software writes the control register
    AST_DONE_STICKY: assert property (@(posedge i_clock) disable iff (i_rst)
        (done_q && !wr_ctrl) |=> done_q)
        else $error("Done flag cleared by itself");

    // Writing zero to the done bit clears it when no completion coincides
    AST_DONE_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
        (done_q && wr_ctrl && !i_reg_wdata[`NVBAC_BIT_DONE] && !finish) |=> !done_q)
        else $error("Done flag not cleared by software");

    // Unused control bits and the fetch bit read as zero
    AST_CTRL_LAYOUT: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == `NVBAC_OFS_CTRL)
        |=> (o_reg_rdata[7:5] == 3'b000 && !o_reg_rdata[0]))
        else $error("Control register layout wrong");

    // Interrupt needs the flag and the global enable
    AST_IRQ_GATE: assert property (@(posedge i_clock) disable iff (i_rst)
        o_store_done_irq |-> (done_q && $past(i_global_irq_enable)))
        else $error("Interrupt without flag or enable");

    // Interrupt also needs its own enable bit
    AST_IRQ_NEEDS_EN: assert property (@(posedge i_clock) disable iff (i_rst)
        o_store_done_irq |-> $past(i_store_done_irq_enable))
        else $error("Interrupt without its own enable");

    // Flag and both enables raise the interrupt on the next edge
    AST_IRQ_RAISE: assert property (@(posedge i_clock) disable iff (i_rst)
        (done_q && !wr_ctrl && i_global_irq_enable && i_store_done_irq_enable)
        |=> o_store_done_irq)
        else $error("Interrupt missing with flag and enables");

    // Done sets on completion even with the interrupt masked
    AST_DONE_UNMASKED: assert property (@(posedge i_clock) disable iff (i_rst)
        (finish && !(i_global_irq_enable && i_store_done_irq_enable)) |=> done_q)
        else $error("Done flag gated by interrupt enables");
endmodule

// *** rtl/nvbac_defines.svh ***
// Register offsets, field positions, unlock values and timing counts
`ifndef NVBAC_DEFINES_SVH
`define NVBAC_DEFINES_SVH
`define NVBAC_OFS_DATA      8'h08
`define NVBAC_OFS_LOC       8'h09
`define NVBAC_OFS_CTRL      8'h88
`define NVBAC_OFS_UNLOCK    8'h89
`define NVBAC_BIT_FETCH     0
`define NVBAC_BIT_STORE     1
`define NVBAC_BIT_PERMIT    2
`define NVBAC_BIT_FAULT     3
`define NVBAC_BIT_DONE      4
`define NVBAC_IRQC_GIE      7
`define NVBAC_IRQC_DONE_EN  6
`define NVBAC_UNLOCK_FIRST  8'h55
`define NVBAC_UNLOCK_SECOND 8'hAA
`define NVBAC_CTRL_RESET    8'h00
`define NVBAC_STORE_TIME_NS 2000
`define NVBAC_CLK_PERIOD_NS 25
`define NVBAC_STORE_CYCLES  ((`NVBAC_STORE_TIME_NS + `NVBAC_CLK_PERIOD_NS - 1) / `NVBAC_CLK_PERIOD_NS)
`endif

// *** rtl/nvbac_pkg.sv ***
// Types shared by the non-volatile byte access controller
package nvbac_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvbac_bus_req_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [5:0] loc;
        logic [7:0] wdata;
    } nvbac_mem_req_t;

    typedef enum logic [1:0] {
        NVBAC_UL_IDLE,
        NVBAC_UL_FIRST,
        NVBAC_UL_ARMED
    } nvbac_unlock_t;
endpackage

// *** rtl/nvbac_mem.sv ***
// Non-volatile byte array model: 64 bytes, registered read data
`timescale 1ns/1ps
module nvbac_mem
    import nvbac_pkg::*;
(
    // Clock
    input  wire logic           i_clock,
    // Access
    input  wire nvbac_mem_req_t i_req,
    output logic [7:0]          o_rdata
);
    logic [7:0] cells_q [0:63];
    logic [7:0] rdata_q;

    // Array has no reset: contents persist like real storage cells
    always_ff @(posedge i_clock) begin
        if (i_req.wr) begin
            cells_q[i_req.loc] <= i_req.wdata;
        end
        if (i_req.rd) begin
            rdata_q <= cells_q[i_req.loc];
        end
    end

    assign o_rdata = rdata_q;
endmodule

// *** rtl/nvbac_unlock.sv ***
// Unlock sequence detector: 55h then AAh on consecutive register writes
`timescale 1ns/1ps
module nvbac_unlock
    import nvbac_pkg::*;
(
    // Clock and reset
    input  wire logic           i_clock,
    input  wire logic           i_rst,
    // Register writes
    input  wire nvbac_bus_req_t i_req,
    input  wire logic           i_consume,
    // Status
    output logic                o_armed
);
`include "nvbac_defines.svh"
    nvbac_unlock_t state_q;
    nvbac_unlock_t state_d;

    // Any write other than the exact next step restarts the sequence
    always_comb begin
        state_d = state_q;
        if (i_consume) begin
            state_d = NVBAC_UL_IDLE;
        end else if (i_req.wr) begin
            case (state_q)
                NVBAC_UL_IDLE: begin
                    if (i_req.addr == `NVBAC_OFS_UNLOCK
                        && i_req.wdata == `NVBAC_UNLOCK_FIRST) begin
                        state_d = NVBAC_UL_FIRST;
                    end
                end
                NVBAC_UL_FIRST: begin
                    if (i_req.addr == `NVBAC_OFS_UNLOCK
                        && i_req.wdata == `NVBAC_UNLOCK_SECOND) begin
                        state_d = NVBAC_UL_ARMED;
                    end else if (i_req.addr == `NVBAC_OFS_UNLOCK
                        && i_req.wdata == `NVBAC_UNLOCK_FIRST) begin
                        state_d = NVBAC_UL_FIRST;
                    end else begin
                        state_d = NVBAC_UL_IDLE;
                    end
                end
                default: begin
                    state_d = NVBAC_UL_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= NVBAC_UL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_armed = (state_q == NVBAC_UL_ARMED);

    AST_UL_ARM_NEEDS_AA: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q != NVBAC_UL_ARMED) ##1 (state_q == NVBAC_UL_ARMED)
        |-> $past(i_req.wdata) == `NVBAC_UNLOCK_SECOND)
        else $error("Unlock armed without second value");
endmodule

// *** verif/nvbac_top_tb.sv ***
// Self-checking bench for the non-volatile byte access controller
`timescale 1ns/1ps
`include "nvbac_defines.svh"
module nvbac_top_tb;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_por = 1'b1;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic [7:0]  o_reg_rdata;
    logic        i_global_irq_enable = 1'b1;
    logic        i_store_done_irq_enable = 1'b1;
    logic        o_store_busy;
    logic        o_store_done_irq;
    logic [31:0] rng = 32'd50260;
    logic [7:0]  v;
    int          n_fail = 0;
    int          num_checks = 0;
    int          run_len = 0;
    int          last_len = 0;
    int          mem_m [64];
    int          dat_m, loc_m, permit_m, done_m;
    int          locs [$];

    always #12.5 i_clock = ~i_clock;

    nvbac_top i_nvbac_top (
        .i_clock(i_clock), .i_rst(i_rst), .i_por(i_por),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_global_irq_enable(i_global_irq_enable),
        .i_store_done_irq_enable(i_store_done_irq_enable),
        .o_store_busy(o_store_busy), .o_store_done_irq(o_store_done_irq));

    // Length of the last busy period, measured apart from the stimulus
    always @(posedge i_clock) begin
        if (o_store_busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len  <= 0;
        end
    end

    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobe stays up into the next task so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_wr    <= 1'b1;
        i_reg_rd    <= 1'b0;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge i_clock);
            i_reg_wr <= 1'b0;
            i_reg_rd <= 1'b0;
        end
    endtask

    // Read data is sampled mid-cycle, well after its register settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_reg_wr   <= 1'b0;
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        @(negedge i_clock);
        d = o_reg_rdata;
    endtask

    task automatic chk_ctrl(input string what);
        rd(`NVBAC_OFS_CTRL, v);
        chk(what, v, 8'(done_m * 16 + permit_m * 4));
    endtask

    task automatic chk_busy(input logic [7:0] exp);
        @(negedge i_clock);
        chk("busy", {7'h00, o_store_busy}, exp);
    endtask

    // Unlock steps and go issued back to back, nothing in between
    task automatic unlock_go(input logic [7:0] a1, input logic [7:0] a2);
        wr(`NVBAC_OFS_UNLOCK, a1);
        wr(`NVBAC_OFS_UNLOCK, a2);
        wr(`NVBAC_OFS_CTRL, 8'h06);
        idle(4);
    endtask

    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        i_por <= 1'b0;
        permit_m = 0;
        done_m = 0;
        chk_ctrl("ctrl_por");
        rd(`NVBAC_OFS_UNLOCK, v);
        chk("unlock_read", v, 8'h00);
        // Go arriving together with permit must not start a store
        unlock_go(`NVBAC_UNLOCK_FIRST, `NVBAC_UNLOCK_SECOND);
        permit_m = 1;
        chk_busy(8'h00);
        unlock_go(`NVBAC_UNLOCK_SECOND, `NVBAC_UNLOCK_FIRST);
        chk_busy(8'h00);
        wr(`NVBAC_OFS_UNLOCK, `NVBAC_UNLOCK_FIRST);
        wr(`NVBAC_OFS_DATA, 8'h3C);
        unlock_go(`NVBAC_UNLOCK_SECOND, `NVBAC_UNLOCK_SECOND);
        chk_busy(8'h00);
        chk_ctrl("ctrl_refused");
        // Three real stores; the second drops permit while running
        for (int k = 0; k < 3; k++) begin
            loc_m = int'(rnd() & 8'h3F);
            dat_m = int'(rnd());
            wr(`NVBAC_OFS_LOC, 8'(loc_m));
            wr(`NVBAC_OFS_DATA, 8'(dat_m));
            wr(`NVBAC_OFS_CTRL, 8'h04);
            permit_m = 1;
            // Last store runs with both enables low: the flag must still set
            i_global_irq_enable     <= (k != 2);
            i_store_done_irq_enable <= (k != 2);
            unlock_go(`NVBAC_UNLOCK_FIRST, `NVBAC_UNLOCK_SECOND);
            chk_busy(8'h01);
            if (k == 1) begin
                wr(`NVBAC_OFS_CTRL, 8'h02);
                idle(1);
                permit_m = 0;
            end
            for (int n = 0; n < 200 && o_store_busy !== 1'b0; n++) begin
                @(negedge i_clock);
            end
            @(negedge i_clock);
            chk("store_len", 8'(last_len), 8'(`NVBAC_STORE_CYCLES));
            mem_m[loc_m] = dat_m;
            done_m = 1;
            chk("irq_done", {7'h00, o_store_done_irq}, 8'(k != 2));
            chk_ctrl("ctrl_done");
            if (k == 2) begin
                chk_ctrl("ctrl_done_masked");
            end
            idle(3);
            chk_ctrl("ctrl_done_held");
            // Flag stays set whatever the enables; only the request is gated
            for (int e = 0; e < 4; e++) begin
                @(posedge i_clock);
                i_global_irq_enable     <= e[1];
                i_store_done_irq_enable <= e[0];
                idle(2);
                @(negedge i_clock);
                chk("irq_gate", {7'h00, o_store_done_irq}, 8'(e == 3));
            end
            wr(`NVBAC_OFS_CTRL, 8'h00); // Permit dropped after each update
            idle(2);
            done_m = 0;
            permit_m = 0;
            chk_ctrl("ctrl_cleared");
            locs.push_back(loc_m);
        end
        // Read every stored byte back through the fetch path
        foreach (locs[j]) begin
            wr(`NVBAC_OFS_LOC, 8'(locs[j]));
            wr(`NVBAC_OFS_CTRL, 8'h01);
            idle(3);
            rd(`NVBAC_OFS_DATA, v);
            chk("fetch", v, 8'(mem_m[locs[j]]));
        end
        loc_m = locs[2] ^ 1;
        wr(`NVBAC_OFS_LOC, 8'(loc_m));
        idle(2);
        rd(`NVBAC_OFS_DATA, v);
        chk("data_held", v, 8'(mem_m[locs[2]]));
        // Warm reset keeps location and data, clears control
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(`NVBAC_OFS_DATA, v);
        chk("data_warm", v, 8'(mem_m[locs[2]]));
        rd(`NVBAC_OFS_LOC, v);
        chk("loc_warm", v, 8'(loc_m));
        chk_ctrl("ctrl_warm");
        // Reset that cuts a running store leaves the fault flag set
        wr(`NVBAC_OFS_CTRL, 8'h04);
        unlock_go(`NVBAC_UNLOCK_FIRST, `NVBAC_UNLOCK_SECOND);
        chk_busy(8'h01);
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(`NVBAC_OFS_CTRL, v);
        chk("ctrl_fault", v, 8'h08);
        wr(`NVBAC_OFS_CTRL, 8'h00);
        chk_ctrl("fault_cleared");
        complete_run();
    end

    // Hang guard: the whole sequence needs about 450 cycles
    initial begin
        repeat (5000) @(posedge i_clock);
        n_fail++;
        complete_run();
    end
endmodule
